/* File: dmr_event_route.sv */
// pending event and interrupt line state driven by send/wait event instructions
`timescale 1ns/10ps
module dmr_event_route
    import dmr_pkg::*;
#(
    parameter int NUM_RES = 32
)
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // routing selection
    input  wire logic [NUM_RES-1:0] routing,
    // instruction strobes
    input  wire logic               sendEventInstr,
    input  wire logic [EVT_W-1:0]   sendEventNum,
    input  wire logic               waitForEventInstr,
    input  wire logic [EVT_W-1:0]   waitForEventNum,
    // pending clear register write
    input  wire logic               pendingClearWr,
    input  wire logic [NUM_RES-1:0] pendingClearMask,
    // outputs
    output logic      [NUM_RES-1:0] eventActive,
    output logic      [NUM_RES-1:0] irq
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic [NUM_RES-1:0] resHit(input logic vld, input logic [EVT_W-1:0] num);
        logic [RES_MAX-1:0] full;
        full = '0;
        if (vld && (32'(num) < NUM_RES))
            full[num] = 1'b1;
        return full[NUM_RES-1:0];
    endfunction : resHit

    logic [NUM_RES-1:0] evt_reg;
    logic [NUM_RES-1:0] evt_next;
    logic [NUM_RES-1:0] irq_reg;
    logic [NUM_RES-1:0] irq_next;
    logic [NUM_RES-1:0] sevHit;
    logic [NUM_RES-1:0] wfeHit;
    logic [NUM_RES-1:0] clrHit;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        sevHit   = resHit(sendEventInstr, sendEventNum);
        wfeHit   = resHit(waitForEventInstr, waitForEventNum);
        clrHit   = pendingClearWr ? pendingClearMask : '0;
        // a new send in the same cycle beats the clear
        evt_next = (evt_reg & ~wfeHit) | (sevHit & ~routing);
        irq_next = (irq_reg & ~clrHit) | (sevHit & routing);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            evt_reg <= '0;
            irq_reg <= '0;
        end
        else
        begin
            evt_reg <= evt_next;
            irq_reg <= irq_next;
        end
    end

    assign eventActive = evt_reg;
    assign irq         = irq_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_SEV_TO_EVENT: assert property (@(posedge clk) disable iff (rst)
        sendEventInstr && (32'(sendEventNum) < NUM_RES) && !routing[sendEventNum]
            && !irq[sendEventNum]
        |=> eventActive[$past(sendEventNum)] && !irq[$past(sendEventNum)])
        else $error("routed event did not reach the threads");

    AST_SEV_TO_IRQ: assert property (@(posedge clk) disable iff (rst)
        sendEventInstr && (32'(sendEventNum) < NUM_RES) && routing[sendEventNum]
        |=> irq[$past(sendEventNum)])
        else $error("routed interrupt line not raised");

    AST_IRQ_HOLD: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> (($past(irq) & ~($past(pendingClearWr) ? $past(pendingClearMask) : '0))
                  & ~irq) == '0)
        else $error("interrupt line dropped without a clear write");

    AST_WFE_CLEARS: assert property (@(posedge clk) disable iff (rst)
        waitForEventInstr && (32'(waitForEventNum) < NUM_RES)
            && !(sendEventInstr && (sendEventNum == waitForEventNum))
        |=> !eventActive[$past(waitForEventNum)])
        else $error("pending event not cleared by wait for event");

    COV_EVENT_WAKE: cover property (@(posedge clk) disable iff (rst)
        (eventActive != '0) ##[1:20] (waitForEventInstr && eventActive[waitForEventNum]));

    COV_IRQ_CLEAR: cover property (@(posedge clk) disable iff (rst)
        (irq != '0) ##[1:20] (pendingClearWr && ((pendingClearMask & irq) != '0)));

endmodule : dmr_event_route

/* File: dmr_pkg.sv */
// constants shared by the manager status and event routing register bank
package dmr_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;
    localparam int EVT_W   = 5;
    localparam int RES_MAX = 32;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MGR_STATUS = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_MGR_PC     = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_ROUTING    = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_CLEAR      = 12'h02C;

    // ------------------------------------------------------------------
    // manager status fields
    // ------------------------------------------------------------------
    localparam int NS_BIT    = 9;
    localparam int WAKE_MSB  = 8;
    localparam int WAKE_LSB  = 4;
    localparam int STATE_MSB = 3;
    localparam int STATE_LSB = 0;

    // ------------------------------------------------------------------
    // manager operating state codes
    // ------------------------------------------------------------------
    localparam logic [3:0] MST_STOPPED   = 4'h0;
    localparam logic [3:0] MST_EXECUTING = 4'h1;
    localparam logic [3:0] MST_CACHEMISS = 4'h2;
    localparam logic [3:0] MST_UPDATEPC  = 4'h3;
    localparam logic [3:0] MST_WAITEVENT = 4'h4;
    localparam logic [3:0] MST_FAULTING  = 4'hF;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] ROUTING_RESET    = 32'h0000_0000;
    localparam logic [1:0]        BOOT_SYNC_CYCLES = 2'h2;

endpackage : dmr_pkg

/* File: dmr_status_route.sv */
// manager status, program counter, event routing and pending clear registers
// Behaviour
// - status bit 9 shows manager security, 0 secure, 1 non-secure.
// - security comes from the startup non-secure input, driven by system.
// - status bits 8:4 show the event number the manager waits for.
// - status bits 3:0 show manager operating state code.
// - program counter register returns the manager's 32-bit program counter.
// - routing register has one bit per event-interrupt resource, 32 bits.
// - routing bit 0: send event signals event to all threads, no interrupt.
// - routing bit 1: send event drives interrupt line N high.
// - interrupt bit falls only after software writes 1 to its clear bit.
// - routed event clears when a thread waits for that event.
`timescale 1ns/10ps
module dmr_status_route
    import dmr_pkg::*;
#(
    parameter int NUM_RES = 32
)
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // peripheral register port
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic      [DATA_W-1:0]  prdata,
    output logic                    pready,
    output logic                    pslverr,
    // startup strap
    input  wire logic               startupManagerNonsecure,
    // manager thread state
    input  wire logic [3:0]         managerState,
    input  wire logic [EVT_W-1:0]   managerWakeEvent,
    input  wire logic [DATA_W-1:0]  managerPcValue,
    // instruction strobes
    input  wire logic               sendEventInstr,
    input  wire logic [EVT_W-1:0]   sendEventNum,
    input  wire logic               waitForEventInstr,
    input  wire logic [EVT_W-1:0]   waitForEventNum,
    // event, interrupt and security flag outputs
    output logic      [NUM_RES-1:0] eventActive,
    output logic      [NUM_RES-1:0] irq,
    output logic                    managerNonsecureFlag
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    if ((NUM_RES < 1) || (NUM_RES > RES_MAX))
    begin : g_bad_num_res
        $error("NUM_RES must lie between 1 and 32");
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        return addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
    endfunction : isReg

    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        return isReg(addr, OFS_MGR_STATUS) || isReg(addr, OFS_MGR_PC)
            || isReg(addr, OFS_ROUTING) || isReg(addr, OFS_CLEAR);
    endfunction : isMapped

    logic setupPhase;
    logic accessPhase;
    logic wrAccess;

    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign wrAccess    = accessPhase && pwrite && isMapped(paddr);
    assign pready      = 1'b1;
    assign pslverr     = accessPhase && !isMapped(paddr);

    // ------------------------------------------------------------------
    // startup security capture
    // ------------------------------------------------------------------
    logic       nsSyncA_reg;
    logic       nsSyncB_reg;
    logic [1:0] bootCnt_reg;
    logic [1:0] bootCnt_next;
    logic       bootDone_reg;
    logic       bootDone_next;
    logic       nsFlag_reg;
    logic       nsFlag_next;

    always_comb
    begin
        bootCnt_next  = bootCnt_reg;
        bootDone_next = bootDone_reg;
        nsFlag_next   = nsFlag_reg;
        if (!bootDone_reg)
        begin
            if (bootCnt_reg == BOOT_SYNC_CYCLES)
            begin
                // taken once after reset, held until the next reset
                nsFlag_next   = nsSyncB_reg;
                bootDone_next = 1'b1;
            end
            else
            begin
                bootCnt_next = bootCnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nsSyncA_reg  <= 1'b0;
            nsSyncB_reg  <= 1'b0;
            bootCnt_reg  <= 2'h0;
            bootDone_reg <= 1'b0;
            nsFlag_reg   <= 1'b0;
        end
        else
        begin
            nsSyncA_reg  <= startupManagerNonsecure;
            nsSyncB_reg  <= nsSyncA_reg;
            bootCnt_reg  <= bootCnt_next;
            bootDone_reg <= bootDone_next;
            nsFlag_reg   <= nsFlag_next;
        end
    end

    assign managerNonsecureFlag = nsFlag_reg;

    // ------------------------------------------------------------------
    // routing register and read data
    // ------------------------------------------------------------------
    logic [NUM_RES-1:0] routing_reg;
    logic [NUM_RES-1:0] routing_next;
    logic [DATA_W-1:0]  prdata_reg;
    logic [DATA_W-1:0]  prdata_next;
    logic [DATA_W-1:0]  routingWide;
    logic               clearWr;

    always_comb
    begin
        routingWide                = '0;
        routingWide[NUM_RES-1:0]   = routing_reg;
        routing_next               = routing_reg;
        clearWr                    = wrAccess && isReg(paddr, OFS_CLEAR);
        if (wrAccess && isReg(paddr, OFS_ROUTING))
            routing_next = pwdata[NUM_RES-1:0];
        // status and counter ignore writes
        prdata_next = prdata_reg;
        if (setupPhase)
        begin
            prdata_next = '0;
            if (isReg(paddr, OFS_MGR_STATUS))
            begin
                prdata_next[NS_BIT]              = nsFlag_reg;
                prdata_next[WAKE_MSB:WAKE_LSB]   = managerWakeEvent;
                prdata_next[STATE_MSB:STATE_LSB] = managerState;
            end
            else if (isReg(paddr, OFS_MGR_PC))
                prdata_next = managerPcValue;
            else if (isReg(paddr, OFS_ROUTING))
                prdata_next = routingWide;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            routing_reg <= ROUTING_RESET[NUM_RES-1:0];
            prdata_reg  <= '0;
        end
        else
        begin
            routing_reg <= routing_next;
            prdata_reg  <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    // ------------------------------------------------------------------
    // event and interrupt state
    // ------------------------------------------------------------------
    dmr_event_route #(
        .NUM_RES (NUM_RES)
    ) u_event_route (
        .clk               (clk),
        .rst               (rst),
        .routing           (routing_reg),
        .sendEventInstr    (sendEventInstr),
        .sendEventNum      (sendEventNum),
        .waitForEventInstr (waitForEventInstr),
        .waitForEventNum   (waitForEventNum),
        .pendingClearWr    (clearWr),
        .pendingClearMask  (pwdata[NUM_RES-1:0]),
        .eventActive       (eventActive),
        .irq               (irq)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_STATUS_NS: assert property (@(posedge clk) disable iff (rst)
        setupPhase && isReg(paddr, OFS_MGR_STATUS)
        |=> prdata[NS_BIT] == $past(managerNonsecureFlag))
        else $error("status security bit differs from manager flag");

    AST_NS_CAPTURE: assert property (@(posedge clk) disable iff (rst)
        $rose(bootDone_reg) |-> managerNonsecureFlag == $past(startupManagerNonsecure, 3))
        else $error("security flag not taken from startup input");

    AST_NS_LOCK: assert property (@(posedge clk) disable iff (rst)
        bootDone_reg |=> $stable(managerNonsecureFlag) && bootDone_reg)
        else $error("security flag changed after capture");

    AST_STATUS_LIVE: assert property (@(posedge clk) disable iff (rst)
        setupPhase && isReg(paddr, OFS_MGR_STATUS)
        |=> prdata[WAKE_MSB:STATE_LSB] == {$past(managerWakeEvent), $past(managerState)}
            && prdata[DATA_W-1:NS_BIT+1] == '0)
        else $error("status read does not show manager wake event and state");

    AST_PC_LIVE: assert property (@(posedge clk) disable iff (rst)
        setupPhase && isReg(paddr, OFS_MGR_PC) |=> prdata == $past(managerPcValue))
        else $error("program counter read stale");

    AST_ROUTE_WRITE: assert property (@(posedge clk) disable iff (rst)
        accessPhase && pwrite && isReg(paddr, OFS_ROUTING)
        ##2 (psel && !penable && !pwrite && isReg(paddr, OFS_ROUTING))
        |=> prdata[NUM_RES-1:0] == $past(pwdata[NUM_RES-1:0], 3))
        else $error("routing register readback differs from write");

    AST_RO_WRITE: assert property (@(posedge clk) disable iff (rst)
        accessPhase && pwrite && !isReg(paddr, OFS_ROUTING) |=> $stable(routing_reg))
        else $error("write to other register changed routing");

    COV_ROUTE_IRQ: cover property (@(posedge clk) disable iff (rst)
        (accessPhase && pwrite && isReg(paddr, OFS_ROUTING) && (pwdata != '0))
        ##[1:20] (irq != '0));

    COV_STATUS_WAIT: cover property (@(posedge clk) disable iff (rst)
        setupPhase && isReg(paddr, OFS_MGR_STATUS) && (managerState == MST_WAITEVENT));

endmodule : dmr_status_route

/* File: tb_dmr_status_route.sv */
// self-checking bench for the manager status and event routing register bank
`timescale 1ns/10ps
module tb_dmr_status_route;
    import dmr_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic              clk;
    logic              rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              startupManagerNonsecure;
    logic [3:0]        managerState;
    logic [EVT_W-1:0]  managerWakeEvent;
    logic [DATA_W-1:0] managerPcValue;
    logic              sendEventInstr;
    logic [EVT_W-1:0]  sendEventNum;
    logic              waitForEventInstr;
    logic [EVT_W-1:0]  waitForEventNum;
    logic [31:0]       eventActive;
    logic [31:0]       irq;
    logic              managerNonsecureFlag;
    int                n_errors;
    int                tests_run;
    logic [DATA_W-1:0] rd;
    logic              err;
    logic [3:0]        codes [6];
    logic [EVT_W-1:0]  wake;

    dmr_status_route #(.NUM_RES(32)) DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .startupManagerNonsecure(startupManagerNonsecure),
        .managerState(managerState), .managerWakeEvent(managerWakeEvent),
        .managerPcValue(managerPcValue), .sendEventInstr(sendEventInstr),
        .sendEventNum(sendEventNum), .waitForEventInstr(waitForEventInstr),
        .waitForEventNum(waitForEventNum), .eventActive(eventActive), .irq(irq),
        .managerNonsecureFlag(managerNonsecureFlag)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer: setup, access, sample at the edge closing access
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] data, output logic slvErr);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1)
        begin
            n_errors++;
            $display("[FAIL] pready expected 1 seen %b", pready);
            end_sim();
        end
        else
        begin
            data = prdata;
            slvErr = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // one instruction pulse, optionally a second on the following cycle
    task automatic pulse(input logic wfe, input logic [4:0] a, input logic two,
                         input logic [4:0] b);
        @(posedge clk);
        if (wfe)
        begin
            waitForEventInstr <= 1'b1;
            waitForEventNum   <= a;
        end
        else
        begin
            sendEventInstr <= 1'b1;
            sendEventNum   <= a;
        end
        if (two)
        begin
            @(posedge clk);
            sendEventNum <= b;
        end
        @(posedge clk);
        sendEventInstr    <= 1'b0;
        waitForEventInstr <= 1'b0;
        @(negedge clk);
    endtask : pulse

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        n_errors = 0;
        tests_run = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        startupManagerNonsecure = 1'b1;
        managerState = MST_STOPPED;
        managerWakeEvent = 5'h00;
        managerPcValue = 32'h0000_0000;
        sendEventInstr = 1'b0;
        sendEventNum = 5'h00;
        waitForEventInstr = 1'b0;
        waitForEventNum = 5'h00;
        codes = '{MST_STOPPED, MST_EXECUTING, MST_CACHEMISS, MST_UPDATEPC, MST_WAITEVENT,
                  MST_FAULTING};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, OFS_ROUTING, 32'h0, rd, err);
        chk("routing reset", ROUTING_RESET, rd);
        repeat (6) @(posedge clk);
        // status fields over every state code, wake number at both ends
        for (int i = 0; i < 6; i++)
        begin
            wake = (i == 5) ? 5'h1F : 5'(i * 5);
            @(posedge clk);
            managerState <= codes[i];
            managerWakeEvent <= wake;
            apb(1'b0, OFS_MGR_STATUS, 32'h0, rd, err);
            chk("status", {22'h0, 1'b1, wake, codes[i]}, rd);
            chk("status err", 32'h0, {31'h0, err});
        end
        chk("ns flag", 32'h1, {31'h0, managerNonsecureFlag});
        apb(1'b1, OFS_MGR_STATUS, 32'hFFFF_FFFF, rd, err);
        chk("status write err", 32'h0, {31'h0, err});
        apb(1'b0, OFS_MGR_STATUS, 32'h0, rd, err);
        chk("status after write", {22'h0, 1'b1, 5'h1F, MST_FAULTING}, rd);
        // program counter follows the live value, writes ignored
        @(posedge clk);
        managerPcValue <= 32'hDEAD_BEEF;
        apb(1'b0, OFS_MGR_PC, 32'h0, rd, err);
        chk("pc", 32'hDEAD_BEEF, rd);
        apb(1'b1, OFS_MGR_PC, 32'h1234_5678, rd, err);
        @(posedge clk);
        managerPcValue <= 32'h8000_0001;
        apb(1'b0, OFS_MGR_PC, 32'h0, rd, err);
        chk("pc live", 32'h8000_0001, rd);
        // routing register holds all 32 bits
        apb(1'b1, OFS_ROUTING, 32'hA5A5_5AF0, rd, err);
        apb(1'b0, OFS_ROUTING, 32'h0, rd, err);
        chk("routing rw", 32'hA5A5_5AF0, rd);
        // unmapped place refused, error flagged on write and read, read returns 0
        apb(1'b1, 12'h100, 32'hFFFF_FFFF, rd, err);
        chk("unmapped write err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h100, 32'h0, rd, err);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped read err", 32'h1, {31'h0, err});
        // event routed to threads, cleared by a matching wait only
        apb(1'b1, OFS_ROUTING, 32'h0000_0008, rd, err);
        pulse(1'b0, 5'd5, 1'b0, 5'd0);
        chk("event 5", 32'h0000_0020, eventActive);
        chk("irq event 5", 32'h0, irq);
        pulse(1'b1, 5'd4, 1'b0, 5'd0);
        chk("event wrong wait", 32'h0000_0020, eventActive);
        pulse(1'b1, 5'd5, 1'b0, 5'd0);
        chk("event wait", 32'h0, eventActive);
        // interrupt path, held until the matching clear bit
        pulse(1'b0, 5'd3, 1'b0, 5'd0);
        chk("irq 3", 32'h0000_0008, irq);
        chk("event irq 3", 32'h0, eventActive);
        pulse(1'b1, 5'd3, 1'b0, 5'd0);
        repeat (4) @(posedge clk);
        #1 chk("irq held", 32'h0000_0008, irq);
        apb(1'b1, OFS_CLEAR, 32'h0000_0004, rd, err);
        @(negedge clk);
        chk("irq other clear", 32'h0000_0008, irq);
        apb(1'b1, OFS_CLEAR, 32'h0000_0008, rd, err);
        @(negedge clk);
        chk("irq cleared", 32'h0, irq);
        apb(1'b0, OFS_CLEAR, 32'h0, rd, err);
        chk("clear reads 0", 32'h0, rd);
        // back to back sends at both ends of the resource range
        apb(1'b1, OFS_ROUTING, 32'h8000_0001, rd, err);
        pulse(1'b0, 5'd31, 1'b1, 5'd0);
        chk("irq ends", 32'h8000_0001, irq);
        pulse(1'b0, 5'd1, 1'b1, 5'd30);
        chk("events b2b", 32'h4000_0002, eventActive);
        chk("irq unchanged", 32'h8000_0001, irq);
        apb(1'b1, OFS_CLEAR, 32'hFFFF_FFFF, rd, err);
        @(negedge clk);
        chk("irq all cleared", 32'h0, irq);
        chk("events kept", 32'h4000_0002, eventActive);
        // mid-run reset with the strap low, captured once and then held
        @(posedge clk);
        startupManagerNonsecure <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("events after reset", 32'h0, eventActive);
        chk("irq after reset", 32'h0, irq);
        apb(1'b0, OFS_ROUTING, 32'h0, rd, err);
        chk("routing after reset", ROUTING_RESET, rd);
        repeat (4) @(posedge clk);
        startupManagerNonsecure <= 1'b1;
        repeat (4) @(posedge clk);
        chk("ns flag low", 32'h0, {31'h0, managerNonsecureFlag});
        apb(1'b0, OFS_MGR_STATUS, 32'h0, rd, err);
        chk("status ns low", {22'h0, 1'b0, 5'h1F, MST_FAULTING}, rd);
        end_sim();
    end

endmodule : tb_dmr_status_route
